// file: src/oscc_regs.sv
// Top: oscillator control register bank on APB with three oscillator cores
//
// Summary of operation
// - Internal osc runs on request when cleared
// - Standby set: internal osc always; deliver after 4
// - Crystal standby bit matters only when enabled
// - Crystal standby clear: request only, active/idle
// - Crystal standby set: all modes, deliver within 3
// - Crystal startup codes 1k/16k/32k/64k cycles
// - Crystal startup and source locked while on
// - Crystal source: crystal or external clock
// - Bit 1 selects crystal low-power mode
// - Enable bit runs crystal, takes pins
// - HF standby: request only, or up to standby
// - HF delivers two cycles after request
// - HF startup codes 256/1K/4K, 3 reserved
// - HF startup and source locked while on
// - HF source: crystal or external clock
// - HF enable runs oscillator, takes pins
// - Crystal status shows stable or clock running
// - HF status shows stable or clock running
`timescale 1ns/1ps
module oscc_regs #(
   parameter int UNLOCK_CYCLES = oscc_pkg::UNLOCK_WINDOW
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] sleep_mode,
   input wire logic ilf_request,
   input wire logic lfx_request,
   input wire logic hfx_request,
   input wire logic ilf_tick,
   input wire logic lfx_tick,
   input wire logic hfx_tick,
   output logic ilf_ready,
   output logic lfx_ready,
   output logic hfx_ready,
   output logic low_freq_crystal_status,
   output logic high_freq_external_status,
   output logic lfx_pins_owned,
   output logic lfx_ext_clock,
   output logic low_power_crystal_mode,
   output logic hfx_pins_owned,
   output logic hfx_ext_clock
);
   // The window counter is eight bits wide
   if (UNLOCK_CYCLES < 1 || UNLOCK_CYCLES > 255) begin : g_bad_unlock
      $error("UNLOCK_CYCLES out of range");
   end

   logic [7:0] internal_low_freq_osc_control;
   logic [7:0] low_freq_crystal_osc_control;
   logic [7:0] high_freq_external_osc_control;
   logic [7:0] unlock_cnt;
   logic access;
   logic wr;
   logic unlocked;
   logic lfx_locked;
   logic hfx_locked;
   logic lfx_run_always;
   logic hfx_run_always;
   logic [7:0] wbyte;

   oscc_osc_if ilf_if ();
   oscc_osc_if lfx_if ();
   oscc_osc_if hfx_if ();

   assign access = psel && penable;
   // Writes land once, at the edge that completes the transfer
   assign wr = access && pready && pwrite;
   assign wbyte = pwdata[7:0];
   assign unlocked = (unlock_cnt != 8'h00);

   // ---------------------------------------------------------------
   // Protection unlock
   // ---------------------------------------------------------------
   // Key opens a short window; any protected write consumes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_cnt <= 8'h00;
      end else if (wr && paddr == oscc_pkg::ADDR_UNLOCK &&
                   wbyte == oscc_pkg::UNLOCK_KEY) begin
         unlock_cnt <= 8'(UNLOCK_CYCLES);
      end else if (wr && (paddr == oscc_pkg::ADDR_ILF_CTRL ||
                   paddr == oscc_pkg::ADDR_LFX_CTRL ||
                   paddr == oscc_pkg::ADDR_HFX_CTRL)) begin
         unlock_cnt <= 8'h00;
      end else if (unlocked) begin
         unlock_cnt <= unlock_cnt - 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   assign lfx_locked = low_freq_crystal_osc_control[oscc_pkg::BIT_ENABLE]
      || lfx_if.stable;
   assign hfx_locked = high_freq_external_osc_control[oscc_pkg::BIT_ENABLE]
      || hfx_if.stable;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         internal_low_freq_osc_control <= oscc_pkg::RESET_CTRL;
      end else if (wr && unlocked &&
                   paddr == oscc_pkg::ADDR_ILF_CTRL) begin
         internal_low_freq_osc_control <= wbyte & oscc_pkg::ILF_WMASK;
      end
   end

   // Locked fields keep their old value; the rest still accept writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_freq_crystal_osc_control <= oscc_pkg::RESET_CTRL;
      end else if (wr && unlocked && paddr == oscc_pkg::ADDR_LFX_CTRL) begin
         if (lfx_locked) begin
            low_freq_crystal_osc_control <=
               (low_freq_crystal_osc_control & oscc_pkg::LFX_LOCK_MASK) |
               (wbyte & oscc_pkg::LFX_WMASK &
                ~oscc_pkg::LFX_LOCK_MASK);
         end else begin
            low_freq_crystal_osc_control <=
               wbyte & oscc_pkg::LFX_WMASK;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         high_freq_external_osc_control <= oscc_pkg::RESET_CTRL;
      end else if (wr && unlocked && paddr == oscc_pkg::ADDR_HFX_CTRL) begin
         if (hfx_locked) begin
            high_freq_external_osc_control <=
               (high_freq_external_osc_control & oscc_pkg::HFX_LOCK_MASK) |
               (wbyte & oscc_pkg::HFX_WMASK &
                ~oscc_pkg::HFX_LOCK_MASK);
         end else begin
            high_freq_external_osc_control <=
               wbyte & oscc_pkg::HFX_WMASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // Oscillator steering
   // ---------------------------------------------------------------
   // Internal osc has no enable bit: it is always available on request
   assign ilf_if.enable = 1'b1;
   assign ilf_if.run_always =
      internal_low_freq_osc_control[oscc_pkg::BIT_RUN_STDBY];
   assign ilf_if.request = ilf_request;
   assign ilf_if.ext_clk = 1'b0;
   assign ilf_if.sut_cycles = 17'h00001;
   assign ilf_if.deliver_cycles = 3'(oscc_pkg::ILF_DELIVER);

   // Without standby bit only active and idle modes honour requests
   assign lfx_run_always =
      low_freq_crystal_osc_control[oscc_pkg::BIT_RUN_STDBY];
   assign lfx_if.enable =
      low_freq_crystal_osc_control[oscc_pkg::BIT_ENABLE];
   assign lfx_if.run_always = lfx_run_always;
   assign lfx_if.request = lfx_request && (lfx_run_always ||
      sleep_mode == oscc_pkg::MODE_ACTIVE ||
      sleep_mode == oscc_pkg::MODE_IDLE);
   assign lfx_if.ext_clk =
      low_freq_crystal_osc_control[oscc_pkg::BIT_LF_SEL];
   // External clock needs only a short settle, crystal the coded wait
   assign lfx_if.sut_cycles = lfx_if.ext_clk ?
      17'(oscc_pkg::EXT_CLK_SETTLE) :
      oscc_pkg::oscc_lf_sut(low_freq_crystal_osc_control[
         oscc_pkg::BIT_SUT_HI:oscc_pkg::BIT_SUT_LO]);
   assign lfx_if.deliver_cycles = 3'(oscc_pkg::LFX_DELIVER);

   // Standby bit never keeps it running in power-down
   assign hfx_run_always =
      high_freq_external_osc_control[oscc_pkg::BIT_RUN_STDBY] &&
      sleep_mode != oscc_pkg::MODE_PDOWN;
   assign hfx_if.enable =
      high_freq_external_osc_control[oscc_pkg::BIT_ENABLE];
   assign hfx_if.run_always = hfx_run_always;
   assign hfx_if.request = hfx_request;
   assign hfx_if.ext_clk =
      high_freq_external_osc_control[oscc_pkg::BIT_HF_SEL];
   // Reserved code 3 falls back to the longest wait
   assign hfx_if.sut_cycles = hfx_if.ext_clk ?
      17'(oscc_pkg::EXT_CLK_SETTLE) :
      oscc_pkg::oscc_hf_sut(high_freq_external_osc_control[
         oscc_pkg::BIT_SUT_HI:oscc_pkg::BIT_SUT_LO]);
   assign hfx_if.deliver_cycles = 3'(oscc_pkg::HFX_DELIVER);

   oscc_osc_core u_ilf (
      .pclk(pclk),
      .presetn(presetn),
      .osc_tick(ilf_tick),
      .osc(ilf_if.core)
   );
   oscc_osc_core u_lfx (
      .pclk(pclk),
      .presetn(presetn),
      .osc_tick(lfx_tick),
      .osc(lfx_if.core)
   );
   oscc_osc_core u_hfx (
      .pclk(pclk),
      .presetn(presetn),
      .osc_tick(hfx_tick),
      .osc(hfx_if.core)
   );

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ilf_ready <= 1'b0;
         lfx_ready <= 1'b0;
         hfx_ready <= 1'b0;
      end else begin
         ilf_ready <= ilf_if.ready;
         lfx_ready <= lfx_if.ready;
         hfx_ready <= hfx_if.ready;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_freq_crystal_status <= 1'b0;
         high_freq_external_status <= 1'b0;
      end else begin
         low_freq_crystal_status <= lfx_if.stable;
         high_freq_external_status <= hfx_if.stable;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfx_pins_owned <= 1'b0;
         lfx_ext_clock <= 1'b0;
         low_power_crystal_mode <= 1'b0;
         hfx_pins_owned <= 1'b0;
         hfx_ext_clock <= 1'b0;
      end else begin
         lfx_pins_owned <= lfx_if.enable;
         lfx_ext_clock <= lfx_if.ext_clk;
         low_power_crystal_mode <=
            low_freq_crystal_osc_control[oscc_pkg::BIT_LF_LP];
         hfx_pins_owned <= hfx_if.enable;
         hfx_ext_clock <= hfx_if.ext_clk;
      end
   end

   // ---------------------------------------------------------------
   // APB read path
   // ---------------------------------------------------------------
   // One wait state: answer on the edge after the access phase starts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (access && !pready) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         case (paddr)
            oscc_pkg::ADDR_ILF_CTRL:
               prdata <= {24'h000000, internal_low_freq_osc_control};
            oscc_pkg::ADDR_LFX_CTRL:
               prdata <= {24'h000000, low_freq_crystal_osc_control};
            oscc_pkg::ADDR_HFX_CTRL:
               prdata <= {24'h000000, high_freq_external_osc_control};
            oscc_pkg::ADDR_STATUS:
               prdata <= {28'h0000000, hfx_if.stable, lfx_if.stable,
                  ilf_if.stable, unlocked};
            oscc_pkg::ADDR_UNLOCK:
               prdata <= 32'h00000000;
            default: begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule : oscc_regs

// file: src/oscc_pkg.sv
// Package: register map, fields, timing constants for oscillator control
package oscc_pkg;
   localparam logic [7:0] ADDR_ILF_CTRL = 8'h18;
   localparam logic [7:0] ADDR_LFX_CTRL = 8'h1c;
   localparam logic [7:0] ADDR_HFX_CTRL = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [7:0] ADDR_UNLOCK = 8'h28;
   localparam logic [7:0] UNLOCK_KEY = 8'hd8;
   localparam int UNLOCK_WINDOW = 4;
   localparam logic [7:0] RESET_CTRL = 8'h00;
   localparam int BIT_RUN_STDBY = 7;
   localparam int BIT_SUT_HI = 5;
   localparam int BIT_SUT_LO = 4;
   localparam int BIT_LF_SEL = 2;
   localparam int BIT_LF_LP = 1;
   localparam int BIT_HF_SEL = 1;
   localparam int BIT_ENABLE = 0;
   localparam logic [7:0] LFX_WMASK = 8'hb7;
   localparam logic [7:0] HFX_WMASK = 8'hb3;
   localparam logic [7:0] ILF_WMASK = 8'h80;
   localparam logic [7:0] LFX_LOCK_MASK = 8'h34;
   localparam logic [7:0] HFX_LOCK_MASK = 8'h32;
   localparam int ILF_DELIVER = 4;
   localparam int LFX_DELIVER = 3;
   localparam int HFX_DELIVER = 2;
   localparam int EXT_CLK_SETTLE = 4;
   typedef enum logic [3:0] {
      OSCC_OFF = 4'b0001,
      OSCC_START = 4'b0010,
      OSCC_STABLE = 4'b0100,
      OSCC_IDLE = 4'b1000
   } oscc_state_t;
   // Sleep modes as seen by the oscillators
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_IDLE = 2'h1;
   localparam logic [1:0] MODE_STANDBY = 2'h2;
   localparam logic [1:0] MODE_PDOWN = 2'h3;
   // Start-up counts per code
   function automatic logic [16:0] oscc_lf_sut(input logic [1:0] c);
      case (c)
         2'h0: return 17'h00400;
         2'h1: return 17'h04000;
         2'h2: return 17'h08000;
         default: return 17'h10000;
      endcase
   endfunction : oscc_lf_sut
   function automatic logic [16:0] oscc_hf_sut(input logic [1:0] c);
      case (c)
         2'h0: return 17'h00100;
         2'h1: return 17'h00400;
         default: return 17'h01000;
      endcase
   endfunction : oscc_hf_sut
endpackage : oscc_pkg

// file: src/oscc_osc_if.sv
// Interface: control and status between register bank and oscillator cores
`timescale 1ns/1ps
interface oscc_osc_if;
   logic enable;
   logic run_always;
   logic request;
   logic ext_clk;
   logic [16:0] sut_cycles;
   logic [2:0] deliver_cycles;
   logic running;
   logic stable;
   logic ready;
   modport ctrl (output enable, run_always, request, ext_clk, sut_cycles,
      deliver_cycles, input running, stable, ready);
   modport core (input enable, run_always, request, ext_clk, sut_cycles,
      deliver_cycles, output running, stable, ready);
endinterface : oscc_osc_if

// file: src/oscc_osc_core.sv
// Oscillator sequencer: start-up count, stability, delivery on request
`timescale 1ns/1ps
module oscc_osc_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic osc_tick,
   oscc_osc_if.core osc
);
   oscc_pkg::oscc_state_t state;
   logic [16:0] count;
   logic [2:0] dcount;
   logic want;
   assign want = osc.enable && (osc.run_always || osc.request);
   assign osc.running = (state == oscc_pkg::OSCC_START) ||
      (state == oscc_pkg::OSCC_STABLE);
   assign osc.stable = (state == oscc_pkg::OSCC_STABLE);
   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Stable state survives loss of request only while kept running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= oscc_pkg::OSCC_OFF;
         count <= 17'h00000;
      end else begin
         case (state)
            oscc_pkg::OSCC_OFF: begin
               if (want) begin
                  state <= oscc_pkg::OSCC_START;
                  count <= 17'h00000;
               end
            end
            oscc_pkg::OSCC_START: begin
               if (!want) begin
                  state <= oscc_pkg::OSCC_OFF;
               end else if (osc_tick) begin
                  count <= count + 17'h00001;
                  if (count + 17'h00001 >= osc.sut_cycles) begin
                     state <= oscc_pkg::OSCC_STABLE;
                  end
               end
            end
            oscc_pkg::OSCC_STABLE: begin
               if (!want) begin
                  state <= oscc_pkg::OSCC_OFF;
               end
            end
            default: state <= oscc_pkg::OSCC_OFF;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // Delivery to requester
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dcount <= 3'h0;
         osc.ready <= 1'b0;
      end else if (!osc.request || state != oscc_pkg::OSCC_STABLE) begin
         dcount <= 3'h0;
         osc.ready <= 1'b0;
      end else if (osc_tick && !osc.ready) begin
         dcount <= dcount + 3'h1;
         osc.ready <= (dcount + 3'h1 >= osc.deliver_cycles);
      end
   end
endmodule : oscc_osc_core

// file: test/oscc_regs_properties.sv
// Port-level checks for the oscillator control register bank
`timescale 1ns/1ps
module oscc_regs_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] sleep_mode,
   input wire logic ilf_request,
   input wire logic lfx_request,
   input wire logic hfx_request,
   input wire logic ilf_tick,
   input wire logic lfx_tick,
   input wire logic hfx_tick,
   input wire logic ilf_ready,
   input wire logic lfx_ready,
   input wire logic hfx_ready,
   input wire logic low_freq_crystal_status,
   input wire logic high_freq_external_status,
   input wire logic lfx_pins_owned,
   input wire logic lfx_ext_clock,
   input wire logic low_power_crystal_mode,
   input wire logic hfx_pins_owned,
   input wire logic hfx_ext_clock
);
   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic mapped;
   assign mapped = paddr inside {8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
   sequence acc_s;
      psel && penable && !pready;
   endsequence
   // Two quiet cycles first, so a registered ready has surely dropped
   sequence ilf_new_s;
      !ilf_request [*2] ##1 ilf_request;
   endsequence
   sequence hfx_new_s;
      !hfx_request [*2] ##1 hfx_request;
   endsequence
   sequence lf_live_s;
      lfx_request && low_freq_crystal_status && sleep_mode < 2'h2;
   endsequence
   a_answer_next: assert property (acc_s |=> pready)
      else $error("no answer after access phase");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_error_unmapped: assert property (acc_s |=> pslverr == !$past(mapped))
      else $error("error response does not match address");
   a_lf_src_lock: assert property (
      lfx_pins_owned && $past(lfx_pins_owned) |-> $stable(lfx_ext_clock))
      else $error("crystal source changed while enabled");
   a_hf_src_lock: assert property (
      hfx_pins_owned && $past(hfx_pins_owned) |-> $stable(hfx_ext_clock))
      else $error("high source changed while enabled");
   a_lf_ready_stable: assert property (
      $rose(lfx_ready) |-> low_freq_crystal_status)
      else $error("crystal delivered before stable");
   a_hf_ready_stable: assert property (
      $rose(hfx_ready) |-> high_freq_external_status)
      else $error("high oscillator delivered before stable");
   a_ilf_min_wait: assert property (ilf_new_s |=> !ilf_ready [*8])
      else $error("internal oscillator delivered too early");
   a_hf_min_wait: assert property (hfx_new_s |=> !hfx_ready [*3])
      else $error("high oscillator delivered too early");
   a_lf_deliver_bound: assert property (
      lf_live_s |-> ##[0:14] (lfx_ready || !lfx_request))
      else $error("crystal not delivered in time");
   // Ready is two flops behind the request, so allow it one more cycle
   a_lf_no_request: assert property (
      !lfx_request [*3] |-> !lfx_ready)
      else $error("crystal delivered without request");
   a_lf_status_off: assert property (
      !lfx_pins_owned [*3] |-> !low_freq_crystal_status)
      else $error("crystal status set while disabled");
endmodule : oscc_regs_properties

// file: test/oscc_osc_model.sv
// Oscillator source model: cycle ticks for the three oscillator inputs
`timescale 1ns/1ps
module oscc_osc_model #(
   parameter int T = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic lfx_on,
   input wire logic hfx_on,
   output logic ilf_tick,
   output logic lfx_tick,
   output logic hfx_tick
);
   int cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 0;
      end else begin
         cnt <= (cnt == T - 1) ? 0 : cnt + 1;
      end
   end
   // Crystals only swing while their pins belong to the oscillator
   assign ilf_tick = presetn && cnt == 0;
   assign lfx_tick = lfx_on && cnt == 1;
   assign hfx_tick = hfx_on && cnt == T - 1;
endmodule : oscc_osc_model

// file: test/oscc_regs_tb.sv
// Testbench: register bank, write locks and oscillator delivery
`timescale 1ns/1ps
module oscc_regs_tb;
   localparam int T = 3;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] sleep_mode;
   logic ilf_request, lfx_request, hfx_request, ilf_tick, lfx_tick;
   logic hfx_tick, ilf_ready, lfx_ready, hfx_ready, lfx_pins_owned;
   logic low_freq_crystal_status, high_freq_external_status;
   logic lfx_ext_clock, low_power_crystal_mode, hfx_pins_owned;
   logic hfx_ext_clock;
   int err_total = 0;
   int check_count = 0;
   int n;
   // Wide unlock window: the bench idles a cycle between transfers
   oscc_regs #(.UNLOCK_CYCLES(8)) dut (.*);
   oscc_osc_model #(.T(T)) xtal (.pclk, .presetn, .lfx_on(lfx_pins_owned),
      .hfx_on(hfx_pins_owned), .ilf_tick, .lfx_tick, .hfx_tick);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ----
   // Helpers
   // ----
   task automatic wrap_up;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 16) begin
         err_total++;
         wrap_up();
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic pw(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, 8'h28, {24'h0, oscc_pkg::UNLOCK_KEY});
      apb(1'b1, a, d);
   endtask : pw
   function automatic logic sig(input int k);
      case (k)
         0: return low_freq_crystal_status;
         1: return high_freq_external_status;
         2: return ilf_ready;
         3: return lfx_ready;
         default: return hfx_ready;
      endcase
   endfunction : sig
   task automatic wt(input int k, input logic v);
      for (n = 1; n < 5000; n++) begin
         @(posedge pclk);
         if (sig(k) === v) return;
      end
      err_total++;
      wrap_up();
   endtask : wt
   // ----
   // Scenarios
   // ----
   task automatic t_regs;
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, 8'h18 + 8'(4 * i), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b1, 8'h1c, 32'h37);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h0);
      chk(lfx_pins_owned, 1'b0);
      apb(1'b0, 8'h2c, 32'h0);
      chk(se, 1'b1);
   endtask : t_regs
   task automatic t_fields;
      for (int c = 0; c < 4; c++) begin
         pw(8'h1c, {26'h0, 2'(c), 4'h6});
         apb(1'b0, 8'h1c, 32'h0);
         chk(rd, {26'h0, 2'(c), 4'h6});
         chk({lfx_ext_clock, low_power_crystal_mode}, 2'h3);
         pw(8'h20, {26'h0, 2'(c), 4'h2});
         apb(1'b0, 8'h20, 32'h0);
         chk(rd, {26'h0, 2'(c), 4'h2});
         chk(hfx_ext_clock, 1'b1);
      end
      pw(8'h1c, 32'h0);
      pw(8'h20, 32'h0);
      chk({lfx_ext_clock, low_power_crystal_mode}, 2'h0);
   endtask : t_fields
   // Oscillators only start while requested or kept running
   task automatic t_lf_ext;
      pw(8'h1c, 32'h05);
      repeat (2) @(posedge pclk);
      chk({lfx_pins_owned, lfx_ext_clock}, 2'h3);
      pw(8'h1c, 32'h31);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h05);
      lfx_request <= 1'b1;
      wt(0, 1'b1);
      chk(low_freq_crystal_status, 1'b1);
      wt(3, 1'b1);
      chk(lfx_ready, 1'b1);
      sleep_mode <= oscc_pkg::MODE_STANDBY;
      wt(3, 1'b0);
      chk(low_freq_crystal_status, 1'b0);
      repeat (40) @(posedge pclk);
      chk(lfx_ready, 1'b0);
      pw(8'h1c, 32'h85);
      wt(3, 1'b1);
      chk(lfx_ready, 1'b1);
      sleep_mode <= oscc_pkg::MODE_PDOWN;
      repeat (8) @(posedge pclk);
      chk(lfx_ready, 1'b1);
      lfx_request <= 1'b0;
      sleep_mode <= oscc_pkg::MODE_ACTIVE;
      wt(3, 1'b0);
      chk(low_freq_crystal_status, 1'b1);
      pw(8'h1c, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h04);
      chk(lfx_pins_owned, 1'b0);
      wt(0, 1'b0);
      pw(8'h1c, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h0);
   endtask : t_lf_ext
   task automatic t_lf_xtal;
      lfx_request <= 1'b1;
      pw(8'h1c, 32'h01);
      wt(0, 1'b1);
      chk(n >= 1024 * T - 12 && n <= 1024 * T + 12, 1'b1);
      wt(3, 1'b1);
      chk(lfx_ready, 1'b1);
      lfx_request <= 1'b0;
      pw(8'h1c, 32'h0);
      wt(0, 1'b0);
   endtask : t_lf_xtal
   task automatic t_hf;
      hfx_request <= 1'b1;
      pw(8'h20, 32'h01);
      wt(1, 1'b1);
      chk(n >= 256 * T - 12 && n <= 256 * T + 12, 1'b1);
      chk({hfx_pins_owned, hfx_ext_clock}, 2'h2);
      pw(8'h20, 32'h33);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h01);
      pw(8'h20, 32'h81);
      hfx_request <= 1'b0;
      wt(4, 1'b0);
      chk(high_freq_external_status, 1'b1);
      hfx_request <= 1'b1;
      wt(4, 1'b1);
      chk(n >= 2 * T && n <= 2 * T + 6, 1'b1);
      hfx_request <= 1'b0;
      sleep_mode <= oscc_pkg::MODE_PDOWN;
      wt(1, 1'b0);
      chk(high_freq_external_status, 1'b0);
      sleep_mode <= oscc_pkg::MODE_ACTIVE;
      pw(8'h20, 32'h0);
      repeat (2) @(posedge pclk);
      chk(hfx_pins_owned, 1'b0);
   endtask : t_hf
   task automatic t_ilf;
      ilf_request <= 1'b1;
      wt(2, 1'b1);
      chk(n >= 3 * T && n <= 5 * T + 6, 1'b1);
      ilf_request <= 1'b0;
      wt(2, 1'b0);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd[1], 1'b0);
      pw(8'h18, 32'hff);
      apb(1'b0, 8'h18, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd[1], 1'b1);
      chk(ilf_ready, 1'b0);
   endtask : t_ilf
   // ----
   // Main sequence
   // ----
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      sleep_mode = oscc_pkg::MODE_ACTIVE;
      {ilf_request, lfx_request, hfx_request} = 3'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_fields();
      t_lf_ext();
      t_lf_xtal();
      t_hf();
      t_ilf();
      wrap_up();
   end
endmodule : oscc_regs_tb
bind oscc_regs oscc_regs_properties props (.*);
